// ===== src/host_addr_vec.sv
`timescale 1ns/1ps
// Purpose: Host-bus slave decode, eight byte registers and interrupt vector unit
// Assumes: Host bus signals synchronous to CLK_I; Wishbone classic slave for setup
// Notes:   Host strobes are levels; one access counted per strobe rise
//
// What this block does
// R01 - Address belongs to I/O page only when bits 13 to 17 are all one.
// R02 - Bits 3..12 each match a switch: closed needs zero, open needs one.
// R03 - After match, low three address bits pick one of eight byte registers.
// R04 - All ten address switches used; switch n compares address bit n+2.
// R05 - Every vector is a multiple of four; bits 1 and 0 always zero.
// R06 - Only vector bits 2 through 8 are driven onto host data lines.
// R07 - Two sources: input interrupt clears bit 2, output interrupt sets it.
// R08 - Vector bits 3..8 from switches: open gives zero, closed gives one.
// R09 - Six of eight vector switches used, switch n sets bit n+2.
// R10 - Requests made at bus priority level 5 by default, selectable.
// R11 - Offsets 0..7 map to register bytes 0..7; even offsets give words.
// R12 - Vector placed only after grant, held until host acknowledge, then released.
module host_addr_vec (
   input  wire logic        CLK_I,
   input  wire logic        SRST_I,
   // Wishbone classic slave
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [7:0]  ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   output logic      [31:0] DAT_O,
   output logic             ACK_O,
   output logic             ERR_O,
   output logic             INT_O,
   // Host backplane side
   input  wire logic [17:0] HADDR_I,
   input  wire logic        HRD_I,
   input  wire logic        HWR_I,
   input  wire logic        HBYTE_I,
   input  wire logic [15:0] HDAT_I,
   output logic      [15:0] HDAT_O,
   output logic             HDAT_OE_N_O,
   output logic             HREPLY_O,
   output logic             HBR_O,
   output logic      [2:0]  HBR_LEVEL_O,
   input  wire logic        HBG_I,
   input  wire logic        HIACK_I
);
   typedef enum logic [1:0] {IV_IDLE, IV_REQ, IV_DRIVE, IV_DONE} iv_state_e;

   logic [9:0]  addr_sw_reg;
   logic [7:0]  vec_sw_reg;
   logic [2:0]  br_level_reg;
   logic        enable_reg;
   logic [1:0]  irq_req_reg;
   logic [3:0]  status_reg;
   logic [3:0]  mask_reg;
   logic [7:0]  bytes_reg [hostdec_pkg::NUM_BYTES];
   logic [2:0]  last_sel_reg;
   logic        hrd_q_reg;
   logic        hwr_q_reg;
   logic        kind_reg;
   iv_state_e   iv_state_reg;
   iv_state_e   iv_state_next;

   // Address decode
   logic        hit;
   logic [2:0]  sel;
   host_match #(
      .AW (hostdec_pkg::HADDR_W),
      .SW (hostdec_pkg::SEL_W)
   ) u_match (
      .addr_i      (HADDR_I),
      .sw_closed_i (addr_sw_reg),
      .hit_o       (hit),
      .sel_o       (sel)
   );

   wire        host_ok  = hit && enable_reg;
   wire        hrd_rise = HRD_I && !hrd_q_reg && host_ok;
   wire        hwr_rise = HWR_I && !hwr_q_reg && host_ok;
   // Word view: even offset pairs byte sel with sel+1
   wire [2:0]  sel_even = {sel[2:1], 1'b0};
   wire [2:0]  sel_odd  = {sel[2:1], 1'b1};
   wire [15:0] host_word = {bytes_reg[sel_odd], bytes_reg[sel_even]};        // [R11]

   // Vector: only switches 1..6 matter, bits 1:0 fixed zero
   wire [5:0]  vec_hi  = vec_sw_reg[hostdec_pkg::VEC_SW_W-1:0];               // [R08] [R09]
   wire [15:0] vector  = {7'h00, vec_hi, kind_reg, 2'b00};                    // [R05] [R06] [R07]

   // Wishbone decode
   wire        wb_req   = CYC_I && STB_I && !ACK_O && !ERR_O;
   wire        wb_wr    = wb_req && WE_I;
   wire        a_ctrl   = (ADR_I == hostdec_pkg::OFS_CTRL);
   wire        a_addr   = (ADR_I == hostdec_pkg::OFS_ADDR_SW);
   wire        a_vec    = (ADR_I == hostdec_pkg::OFS_VEC_SW);
   wire        a_irq    = (ADR_I == hostdec_pkg::OFS_IRQ_REQ);
   wire        a_stat   = (ADR_I == hostdec_pkg::OFS_STATUS);
   wire        a_mask   = (ADR_I == hostdec_pkg::OFS_MASK);
   wire        a_blo    = (ADR_I == hostdec_pkg::OFS_BYTES_LO);
   wire        a_bhi    = (ADR_I == hostdec_pkg::OFS_BYTES_HI);
   wire        a_last   = (ADR_I == hostdec_pkg::OFS_LASTHIT);
   wire        a_any    = a_ctrl | a_addr | a_vec | a_irq | a_stat | a_mask |
                          a_blo | a_bhi | a_last;
   wire [31:0] bytes_lo = {bytes_reg[3], bytes_reg[2], bytes_reg[1], bytes_reg[0]};
   wire [31:0] bytes_hi = {bytes_reg[7], bytes_reg[6], bytes_reg[5], bytes_reg[4]};
   wire [31:0] rd_mux   = a_ctrl ? {24'h0, 4'h0, br_level_reg, enable_reg} :
                          a_addr ? {22'h0, addr_sw_reg} :
                          a_vec  ? {24'h0, vec_sw_reg} :
                          a_irq  ? {28'h0, iv_state_reg, irq_req_reg} :
                          a_stat ? {28'h0, status_reg} :
                          a_mask ? {28'h0, mask_reg} :
                          a_blo  ? bytes_lo :
                          a_bhi  ? bytes_hi :
                          a_last ? {29'h0, last_sel_reg} : 32'h0;

   // Interrupt events: host accesses and vector deliveries
   wire        iv_done  = (iv_state_reg == IV_DRIVE) && HIACK_I;
   wire [3:0]  ev       = {iv_done && kind_reg, iv_done && !kind_reg, hrd_rise, hwr_rise};
   wire [3:0]  w1c      = (wb_wr && a_stat && SEL_I[0]) ? DAT_I[3:0] : 4'h0;

   // Request pick: input source wins ties
   wire        pick_out = !irq_req_reg[0];

   always_comb begin
      iv_state_next = iv_state_reg;
      unique case (iv_state_reg)
         IV_IDLE:  if (|irq_req_reg) iv_state_next = IV_REQ;
         IV_REQ:   if (HBG_I) iv_state_next = IV_DRIVE;                      // [R12]
         IV_DRIVE: if (HIACK_I) iv_state_next = IV_DONE;                     // [R12]
         IV_DONE:  if (!HBG_I && !HIACK_I) iv_state_next = IV_IDLE;
      endcase
   end

   // Kind is taken once per request, so bit 2 stays put while a vector is out
   wire        kind_load  = (iv_state_reg == IV_IDLE) && (|irq_req_reg);

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         iv_state_reg <= IV_IDLE;
      end else begin
         iv_state_reg <= iv_state_next;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         kind_reg <= 1'b0;
      end else if (kind_load) begin
         kind_reg <= pick_out;                                               // [R07]
      end
   end

   // Pending requests: set by software, cleared when delivered; a set wins
   wire [1:0]  irq_clr      = {iv_done && kind_reg, iv_done && !kind_reg};
   wire [1:0]  irq_set      = (wb_wr && a_irq && SEL_I[0]) ? DAT_I[1:0] : 2'b00;
   wire [1:0]  irq_req_next = (irq_req_reg & ~irq_clr) | irq_set;

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         irq_req_reg <= 2'b00;
      end else begin
         irq_req_reg <= irq_req_next;
      end
   end

   // Set beats clear, so an event in the clearing cycle is never lost
   wire [3:0]  status_next = (status_reg & ~w1c) | ev;

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         status_reg <= 4'h0;
      end else begin
         status_reg <= status_next;
      end
   end

   // Software register write strobes
   wire        wr_ctrl  = wb_wr && a_ctrl && SEL_I[0];
   wire        wr_addr0 = wb_wr && a_addr && SEL_I[0];
   wire        wr_addr1 = wb_wr && a_addr && SEL_I[1];
   wire        wr_vec   = wb_wr && a_vec && SEL_I[0];
   wire        wr_mask  = wb_wr && a_mask && SEL_I[0];

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         br_level_reg <= hostdec_pkg::BR_RST;                                // [R10]
         enable_reg   <= 1'b0;
      end else if (wr_ctrl) begin
         {br_level_reg, enable_reg} <= DAT_I[3:0];                           // [R10]
      end
   end

   // A host access in the cycle of a switch change may see either setting
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         addr_sw_reg <= hostdec_pkg::ADDR_SW_RST;
      end else begin
         if (wr_addr0) addr_sw_reg[7:0] <= DAT_I[7:0];
         if (wr_addr1) addr_sw_reg[9:8] <= DAT_I[9:8];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         vec_sw_reg <= hostdec_pkg::VEC_SW_RST;
      end else if (wr_vec) begin
         vec_sw_reg <= DAT_I[7:0];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         mask_reg <= 4'h0;
      end else if (wr_mask) begin
         mask_reg <= DAT_I[3:0];
      end
   end

   // Byte registers: host writes come last and so win over software
   wire [7:0]  sw_byte_we   = {{4{wb_wr && a_bhi}} & SEL_I, {4{wb_wr && a_blo}} & SEL_I};
   wire        host_byte_wr = hwr_rise && HBYTE_I;
   wire        host_word_wr = hwr_rise && !HBYTE_I;
   wire [7:0]  host_lane    = sel[0] ? HDAT_I[15:8] : HDAT_I[7:0];

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         for (int i = 0; i < hostdec_pkg::NUM_BYTES; i++) begin
            bytes_reg[i] <= 8'h00;
         end
      end else begin
         for (int i = 0; i < hostdec_pkg::NUM_BYTES; i++) begin
            if (sw_byte_we[i]) begin
               bytes_reg[i] <= DAT_I[8*(i%4) +: 8];
            end
         end
         if (host_byte_wr) begin
            bytes_reg[sel] <= host_lane;                                     // [R03]
         end
         if (host_word_wr) begin
            bytes_reg[sel_even] <= HDAT_I[7:0];                              // [R11]
            bytes_reg[sel_odd]  <= HDAT_I[15:8];
         end
      end
   end

   wire        host_take = hwr_rise || hrd_rise;

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         last_sel_reg <= 3'h0;
      end else if (host_take) begin
         last_sel_reg <= sel;                                                // [R03]
      end
   end

   // Strobe history; cleared in reset, but enable also resets low, so a strobe held through reset is never counted
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         hrd_q_reg <= 1'b0;
         hwr_q_reg <= 1'b0;
      end else begin
         hrd_q_reg <= HRD_I;
         hwr_q_reg <= HWR_I;
      end
   end

   // Host-side outputs, each from its own flop
   wire        drive_vec  = (iv_state_next == IV_DRIVE);
   wire        drive_read = host_ok && HRD_I;
   wire        reply_next = drive_vec || (host_ok && (HRD_I || HWR_I));

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         HBR_LEVEL_O <= hostdec_pkg::BR_RST;
      end else begin
         HBR_LEVEL_O <= br_level_reg;                                        // [R10]
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         HBR_O <= 1'b0;
      end else begin
         HBR_O <= (iv_state_next == IV_REQ);                                 // [R12]
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         HREPLY_O <= 1'b0;
      end else begin
         HREPLY_O <= reply_next;
      end
   end

   // The vector comes first, so a grant is never answered with register data
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         HDAT_O      <= 16'h0000;
         HDAT_OE_N_O <= 1'b1;
      end else if (drive_vec) begin
         HDAT_O      <= vector;                                              // [R06] [R12]
         HDAT_OE_N_O <= 1'b0;
      end else if (drive_read) begin
         HDAT_O      <= host_word;                                           // [R11]
         HDAT_OE_N_O <= 1'b0;
      end else begin
         HDAT_O      <= 16'h0000;
         HDAT_OE_N_O <= 1'b1;
      end
   end

   // Wishbone answer, one cycle after request; the answer blocks a second take
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         ACK_O <= 1'b0;
      end else begin
         ACK_O <= wb_req && a_any;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         ERR_O <= 1'b0;
      end else begin
         ERR_O <= wb_req && !a_any;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         DAT_O <= 32'h0;
      end else begin
         DAT_O <= wb_req ? rd_mux : 32'h0;
      end
   end

   // Built from the next status so the level lines up with the sticky bits
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         INT_O <= 1'b0;
      end else begin
         INT_O <= |(status_next & mask_reg);
      end
   end
endmodule : host_addr_vec

// ===== src/hostdec_pkg.sv
// Purpose: Shared constants for the host address decoder and vector unit
// Assumes: 18-bit host address, 16-bit host data, 125 MHz clock
// Notes:   Wishbone register offsets are byte addresses of 32-bit words
package hostdec_pkg;
   localparam int          HADDR_W        = 18;
   localparam int          HDATA_W        = 16;
   localparam int          PAGE_LO        = 13;
   localparam int          PAGE_HI        = 17;
   localparam int          SEL_LO         = 3;
   localparam int          SEL_HI         = 12;
   localparam int          SEL_W          = 10;
   localparam int          VEC_LO         = 3;
   localparam int          VEC_HI         = 8;
   localparam int          VEC_SW_W       = 6;
   localparam int          VEC_SW_ALL     = 8;
   localparam int          VEC_KIND_BIT   = 2;
   localparam int          NUM_BYTES      = 8;
   localparam int          BR_LEVEL_RST   = 5;
   // Wishbone register map
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_ADDR_SW    = 8'h04;
   localparam logic [7:0]  OFS_VEC_SW     = 8'h08;
   localparam logic [7:0]  OFS_IRQ_REQ    = 8'h0c;
   localparam logic [7:0]  OFS_STATUS     = 8'h10;
   localparam logic [7:0]  OFS_MASK       = 8'h14;
   localparam logic [7:0]  OFS_BYTES_LO   = 8'h18;
   localparam logic [7:0]  OFS_BYTES_HI   = 8'h1c;
   localparam logic [7:0]  OFS_LASTHIT    = 8'h20;
   // Status bit positions
   localparam int          ST_HOST_WR     = 0;
   localparam int          ST_HOST_RD     = 1;
   localparam int          ST_IN_DONE     = 2;
   localparam int          ST_OUT_DONE    = 3;
   localparam int          ST_W           = 4;
   // Reset values
   localparam logic [9:0]  ADDR_SW_RST    = 10'h000;
   localparam logic [7:0]  VEC_SW_RST     = 8'h00;
   localparam logic [2:0]  BR_RST         = 3'h5;
endpackage : hostdec_pkg

// ===== src/host_match.sv
`timescale 1ns/1ps
// Purpose: Combinational host address match against page and switch bank
// Assumes: Switch bit 1 means closed (expects address bit 0)
// Notes:   Switch n of the bank compares address bit n+2
module host_match #(
   parameter int AW = hostdec_pkg::HADDR_W,
   parameter int SW = hostdec_pkg::SEL_W
) (
   input  wire logic [AW-1:0] addr_i,
   input  wire logic [SW-1:0] sw_closed_i,
   output logic               hit_o,
   output logic [2:0]         sel_o
);
   wire page_ok = &addr_i[hostdec_pkg::PAGE_HI:hostdec_pkg::PAGE_LO]; // [R01]
   // Closed switch wants zero, open wants one
   wire [SW-1:0] want = ~sw_closed_i;                                  // [R02] [R04]
   wire sel_ok = (addr_i[hostdec_pkg::SEL_HI:hostdec_pkg::SEL_LO] == want);
   assign hit_o = page_ok && sel_ok;
   assign sel_o = addr_i[2:0];                                         // [R03]
endmodule : host_match

// ===== test/host_addr_vec_sva.sv
// Purpose: Port assertions for the host decoder
// Assumes: One clock, reset synchronous, active high
// Notes:   A vector phase is told from a host read by the grant
`timescale 1ns/1ps
module host_addr_vec_sva (
   input wire logic        CLK_I,
   input wire logic        SRST_I,
   input wire logic [17:0] HADDR_I,
   input wire logic        HRD_I,
   input wire logic [15:0] HDAT_O,
   input wire logic        HDAT_OE_N_O,
   input wire logic        HREPLY_O,
   input wire logic        HBR_O,
   input wire logic        HBG_I,
   input wire logic        HIACK_I
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   wire vec_on = !HDAT_OE_N_O && HBG_I && !HRD_I;
   sequence s_grant; HBR_O && HBG_I; endsequence
   sequence s_drive; !HBR_O && vec_on && HREPLY_O; endsequence
   a_page_miss: assert property ($rose(HRD_I) && !HBG_I && HADDR_I[17:13] != 5'h1f
      |=> !HREPLY_O && HDAT_OE_N_O) else $error("reply outside page");
   a_read_drive: assert property (HRD_I && HREPLY_O && !HBG_I |-> !HDAT_OE_N_O)
      else $error("read reply without data");
   a_reply_drop: assert property ($fell(HRD_I) && !HBG_I |=> !HREPLY_O)
      else $error("reply held after strobe");
   a_vec_low: assert property (vec_on |-> HDAT_O[1:0] == 2'h0)
      else $error("vector not a multiple of four");
   a_vec_width: assert property (vec_on |-> HDAT_O[15:9] == 7'h00)
      else $error("vector drives high lines");
   a_vec_grant: assert property (s_grant |=> s_drive)
      else $error("vector not driven after grant");
   a_vec_hold: assert property (vec_on && !HIACK_I |=> vec_on && $stable(HDAT_O))
      else $error("vector dropped early");
   a_vec_release: assert property (vec_on && HIACK_I |-> ##[1:2] HDAT_OE_N_O)
      else $error("vector not released");
   a_no_early_vec: assert property ($fell(HDAT_OE_N_O) && !HRD_I |-> $past(HBG_I))
      else $error("vector before grant");
endmodule : host_addr_vec_sva
bind host_addr_vec host_addr_vec_sva chk (.CLK_I, .SRST_I, .HADDR_I, .HRD_I, .HDAT_O,
   .HDAT_OE_N_O, .HREPLY_O, .HBR_O, .HBG_I, .HIACK_I);

// ===== test/host_model.sv
// Purpose: Host model for strobed accesses and vector handshake
// Assumes: Signals change just after a rising edge
// Notes:   Grant delay alternates to cover prompt and slow hosts
`timescale 1ns/1ps
module host_model (
   input  wire logic        clk_i,
   input  wire logic [15:0] data_i,
   input  wire logic        oe_n_i,
   input  wire logic        reply_i,
   input  wire logic        br_i,
   output logic      [17:0] addr_o = 18'h0,
   output logic             rd_o = 1'b0,
   output logic             wr_o = 1'b0,
   output logic             byte_o = 1'b0,
   output logic      [15:0] data_o = 16'h0,
   output logic             bg_o = 1'b0,
   output logic             iack_o = 1'b0
);
   logic [1:0]  st = 2'h0;
   logic [2:0]  cnt = 3'h0;
   logic [2:0]  dly = 3'h0;
   logic [15:0] vec = 16'h0;
   int          n_vec = 0;
   always @(posedge clk_i) begin
      if (st == 2'h0 && br_i) begin // Grant only a pending request
         st  <= 2'h1;
         cnt <= dly;
      end
      if (st == 2'h1) cnt <= cnt - 3'h1;
      if (st == 2'h1 && cnt == 3'h0) begin
         bg_o <= 1'b1;
         st   <= 2'h2;
      end
      if (st == 2'h2 && reply_i && !oe_n_i) begin
         vec    <= data_i;
         iack_o <= 1'b1;
         st     <= 2'h3;
      end
      if (st == 2'h3 && oe_n_i) begin // Lines free before grant drops
         bg_o   <= 1'b0;
         iack_o <= 1'b0;
         dly    <= dly ^ 3'h4;
         n_vec  <= n_vec + 1;
         st     <= 2'h0;
      end
   end
   task automatic access(input logic [17:0] a, input logic r, input logic [15:0] d,
                         input logic b, output logic rep, output logic [15:0] q);
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= r;
      wr_o   <= !r;
      byte_o <= b;
      data_o <= d;
      repeat (2) @(posedge clk_i);
      rep = reply_i;
      q = data_i;
      rd_o   <= 1'b0;
      wr_o   <= 1'b0;
      data_o <= ~d; // No stale value on a released bus
      @(posedge clk_i);
   endtask : access
endmodule : host_model

// ===== test/host_addr_vec_tb_top.sv
// Purpose: Self-checking bench for the host decoder
// Assumes: Wishbone set-up, host model on the backplane
// Notes:   Base is octal 760200: only switch 5 open
`timescale 1ns/1ps
module host_addr_vec_tb_top;
   localparam logic [17:0] BASE = 18'h3e080;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, q;
   logic [17:0] haddr;
   logic [15:0] hdi, hdo, hq;
   logic [2:0]  lvl;
   logic        ack, err, int_o, hrd, hwr, hbyte, hbg, hiack, oe_n, reply, hbr, e, rep;
   int          err_count = 0;
   int          cmp_count = 0;
   host_addr_vec dut (.CLK_I(clk), .SRST_I(srst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
      .ADR_I(adr), .SEL_I(4'hf), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .ERR_O(err),
      .INT_O(int_o), .HADDR_I(haddr), .HRD_I(hrd), .HWR_I(hwr), .HBYTE_I(hbyte),
      .HDAT_I(hdi), .HDAT_O(hdo), .HDAT_OE_N_O(oe_n), .HREPLY_O(reply), .HBR_O(hbr),
      .HBR_LEVEL_O(lvl), .HBG_I(hbg), .HIACK_I(hiack));
   host_model hm (.clk_i(clk), .data_i(hdo), .oe_n_i(oe_n), .reply_i(reply), .br_i(hbr),
      .addr_o(haddr), .rd_o(hrd), .wr_o(hwr), .byte_o(hbyte), .data_o(hdi), .bg_o(hbg),
      .iack_o(hiack));
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         err_count++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask : chk
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && err !== 1'b1) @(posedge clk);
      q = rdat;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      wb(a, 1'b0, 32'h0);
      chk(q, want);
   endtask : rd
   task automatic hr(input logic [17:0] a, input logic r, input logic [15:0] want);
      hm.access(a, 1'b1, 16'h0, 1'b0, rep, hq);
      chk({31'h0, rep}, {31'h0, r});
      if (r) chk({16'h0, hq}, {16'h0, want});
   endtask : hr
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out
   initial begin
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      $display("BAD %0t watchdog expired", $time);
      close_out;
   end
   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk({29'h0, lvl}, 32'h5);
      rd(8'h00, 32'ha);
      wb(8'h24, 1'b0, 32'h0);
      chk({31'h0, e}, 32'h1);
      wb(8'h04, 1'b1, 32'h3ef);
      rd(8'h04, 32'h3ef);
      hr(BASE, 1'b0, 16'h0);
      wb(8'h00, 1'b1, 32'hb);
      hm.access(BASE, 1'b0, 16'ha55a, 1'b0, rep, hq);
      hm.access(BASE + 18'h2, 1'b0, 16'h1234, 1'b0, rep, hq);
      hm.access(BASE + 18'h3, 1'b0, 16'hc3ff, 1'b1, rep, hq);
      hr(BASE, 1'b1, 16'ha55a);
      hr(BASE + 18'h2, 1'b1, 16'hc334);
      rd(8'h18, 32'hc334a55a);
      rd(8'h20, 32'h2);
      for (int b = 3; b < 18; b++) hr(BASE ^ (18'h1 << b), 1'b0, 16'h0);
      $display("decode test done");
      wb(8'h08, 1'b1, 32'hc5);
      wb(8'h14, 1'b1, 32'hc);
      chk({31'h0, int_o}, 32'h0);
      wb(8'h0c, 1'b1, 32'h3);
      while (hm.n_vec < 1) @(posedge clk);
      chk({16'h0, hm.vec}, 32'h28);
      while (hm.n_vec < 2) @(posedge clk);
      chk({16'h0, hm.vec}, 32'h2c);
      rd(8'h10, 32'hf);
      chk({31'h0, int_o}, 32'h1);
      wb(8'h14, 1'b1, 32'h0);
      chk({31'h0, int_o}, 32'h0);
      wb(8'h14, 1'b1, 32'hc);
      chk({31'h0, int_o}, 32'h1);
      wb(8'h10, 1'b1, 32'hf);
      rd(8'h10, 32'h0);
      chk({31'h0, int_o}, 32'h0);
      wb(8'h00, 1'b1, 32'h7);
      chk({29'h0, lvl}, 32'h3);
      $display("interrupt test done");
      close_out;
   end
endmodule : host_addr_vec_tb_top
